// *** asp_pkg.sv ***
/*
  Shared constants and state encodings for the four-mode asynchronous serial
  port. Assumes a single peripheral clock drives the whole port.
*/
package asp_pkg;

  // ----------------------------------------------------------------------
  // rate constants
  // ----------------------------------------------------------------------
  localparam int OVERSAMPLE    = 16;              // line samples per bit
  localparam int MODE0_DIV     = 2;               // shift register rate
  localparam int MODE2_DIV     = 64;              // fixed 9-bit rate
  localparam int MODE2_OS_DIV  = MODE2_DIV / OVERSAMPLE;
  localparam logic [1:0] PRE_LAST = 2'(MODE2_OS_DIV - 1);

  // ----------------------------------------------------------------------
  // mode codes {mode_select_high, mode_select_low}
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_8VAR  = 2'h1;
  localparam logic [1:0] MODE_9FIX  = 2'h2;
  localparam logic [1:0] MODE_9VAR  = 2'h3;

  // ----------------------------------------------------------------------
  // frame and counter constants
  // ----------------------------------------------------------------------
  localparam logic [3:0] FRAME8_BITS = 4'hA;      // start + 8 + stop
  localparam logic [3:0] FRAME9_BITS = 4'hB;      // start + 9 + stop
  localparam logic [3:0] RX8_BITS    = 4'h9;      // 8 data + stop
  localparam logic [3:0] RX9_BITS    = 4'hA;      // 9 data + stop
  localparam logic [3:0] SHIFT_BITS  = 4'h8;
  localparam logic [3:0] OS_LAST     = 4'hF;
  localparam logic [3:0] OS_MID      = 4'h7;
  localparam logic [7:0] SYNC_BYTE   = 8'h55;
  localparam int BAUD_W = 11;
  localparam int FRAC_W = 8;
  localparam logic RST_LINE = 1'b1;              // idle line level

  // ----------------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ASP_TX_IDLE = 2'b01,
    ASP_TX_BUSY = 2'b10
  } asp_tx_e;

  typedef enum logic [2:0] {
    ASP_RX_IDLE  = 3'b001,
    ASP_RX_START = 3'b010,
    ASP_RX_DATA  = 3'b100
  } asp_rx_e;

endpackage

// *** asp_baud.sv ***
/*
  Dedicated baud-rate generator with fractional divider. Produces a one-cycle
  oversampling tick on each underflow. Assumes control inputs are synchronous.
*/
`timescale 1ns/1ps
module asp_baud
  import asp_pkg::*;
(
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  // control
  input  wire logic                baud_enable,
  input  wire logic [BAUD_W-1:0]   baud_reload,
  input  wire logic [FRAC_W-1:0]   frac_step,
  // tick out
  output logic                     os_tick
);
  import asp_pkg::*;

  typedef struct packed {
    logic [FRAC_W-1:0] acc;
    logic [BAUD_W-1:0] cnt;
    logic              tick;
  } asp_baud_s;

  asp_baud_s s;
  asp_baud_s next_s;
  logic      carry;

  // ----------------------------------------------------------------------
  // divider: accumulator carry stalls the counter for fractional periods
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    carry = 1'b0;
    if (!baud_enable)
    begin
      next_s.cnt = baud_reload;
      next_s.acc = '0;
    end
    else
    begin
      {carry, next_s.acc} = {1'b0, s.acc} + {1'b0, frac_step};
      if (!carry)
      begin
        if (s.cnt == '0)
        begin
          next_s.cnt  = baud_reload;
          next_s.tick = 1'b1;
        end
        else
        begin
          next_s.cnt = s.cnt - 1'b1;
        end
      end
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign os_tick = s.tick;

endmodule

// *** asp_core.sv ***
/*
  Four-mode full-duplex serial port with buffered receiver, break and sync
  byte detection. Assumes software strobes are one-cycle pulses on core_clk
  and the serial inputs are asynchronous pins.
*/
// Functional notes
// - two select bits choose one of four modes
// - mode 0 shifts 8 bits at clock/2
// - mode 1: 8-bit frames at generator rate
// - modes 2/3 9-bit; mode 2 at clock/64
// - variable rate comes from generator underflow
// - generator has a fractional divider
// - frames of 8 or 9 bits, LSB first
// - transmitter and receiver run independently in modes 1-3
// - receive holding register frees the shifter
// - unread byte on completion: one is lost
// - data write loads and starts transmitter
// - data read returns separate receive register
// - interrupt on transmit and receive completion
// - detect break and sync byte on receive
// - first port: transceiver or test pins
`timescale 1ns/1ps
module asp_core
  import asp_pkg::*;
#(
  parameter bit IS_FIRST = 1'b1
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // configuration
  input  wire logic        mode_select_high,
  input  wire logic        mode_select_low,
  input  wire logic        rx_enable,
  input  wire logic        test_sel,
  input  wire logic [10:0] baud_reload,
  input  wire logic [7:0]  frac_step,
  // serial_data_buffer access
  input  wire logic        tx_write,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_bit9,
  input  wire logic        rd_strobe,
  output logic [7:0]       serial_data_buffer,
  output logic             rx_bit9,
  // flags
  input  wire logic        clr_tx_flag,
  input  wire logic        clr_rx_flag,
  input  wire logic        clr_err_flags,
  output logic             tx_busy,
  output logic             rx_full,
  output logic             tx_flag,
  output logic             rx_flag,
  output logic             overrun,
  output logic             brk_flag,
  output logic             sync_flag,
  output logic             irq,
  // serial pins
  input  wire logic        lin_rxd,
  input  wire logic        gpio_rxd,
  output logic             lin_txd,
  output logic             gpio_txd,
  output logic             shift_clk
);
  import asp_pkg::*;

  typedef struct packed {
    logic       sync1, sync2, prev;
    logic [1:0] pre;
    asp_tx_e    tx_state;
    logic [10:0] tx_shift;
    logic [3:0] tx_cnt, tx_os;
    asp_rx_e    rx_state;
    logic [9:0] rx_shift;
    logic [3:0] rx_cnt, rx_os;
    logic [7:0] rx_data;
    logic       rx_b9, full, txf, rxf, ovr, brk, syn, brk_seen;
    logic       busy, txd, sclk, irq, lin_txd, gpio_txd;
  } asp_core_s;

  asp_core_s  s;
  asp_core_s  next_s;
  logic [1:0] mode;
  logic       nine, os_tick, baud_tick, rx_pin;
  logic       load_rx, check_lin;
  logic [7:0] ld_data;
  logic       ld_b9;
  logic [9:0] f;

  // ----------------------------------------------------------------------
  // mode decode and rate selection
  // ----------------------------------------------------------------------
  assign mode = {mode_select_high, mode_select_low};
  assign nine = mode[1];
  // first instance: transceiver, or test pins when test_sel is high
  assign rx_pin = (IS_FIRST && !test_sel) ? lin_rxd : gpio_rxd;
  // mode 2 ticks every 4 clocks: 16 ticks make 64 clocks per bit
  assign os_tick = (mode == MODE_9FIX) ? (s.pre == PRE_LAST)
                 : ((mode != MODE_SHIFT) && baud_tick);

  asp_baud u_baud (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .baud_enable (mode[0]),
    .baud_reload (baud_reload),
    .frac_step   (frac_step),
    .os_tick     (baud_tick)
  );

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    load_rx = 1'b0;
    check_lin = 1'b0;
    ld_data = '0;
    ld_b9 = 1'b0;
    f = {s.sync2, s.rx_shift[9:1]};
    next_s.sync1 = rx_pin;
    next_s.sync2 = s.sync1;
    next_s.prev  = s.sync2;
    next_s.pre   = s.pre + 2'h1;
    // software clears first so that hardware sets below win
    if (clr_tx_flag) next_s.txf = 1'b0;
    if (clr_rx_flag) next_s.rxf = 1'b0;
    if (clr_err_flags)
    begin
      next_s.ovr = 1'b0;
      next_s.brk = 1'b0;
      next_s.syn = 1'b0;
    end
    if (rd_strobe) next_s.full = 1'b0;

    // transmitter, independent of the receiver machine
    unique case (s.tx_state)
      ASP_TX_IDLE:
      begin
        next_s.sclk = 1'b1;
        if (tx_write)
        begin
          next_s.tx_state = ASP_TX_BUSY;
          next_s.tx_os = '0;
          if (mode == MODE_SHIFT)
          begin
            next_s.txd = tx_data[0];
            next_s.tx_shift = {4'hF, tx_data[7:1]};
            next_s.tx_cnt = SHIFT_BITS;
          end
          else
          begin
            next_s.tx_shift = {1'b1, nine ? tx_bit9 : 1'b1, tx_data, 1'b0};
            next_s.tx_cnt = nine ? FRAME9_BITS : FRAME8_BITS;
            next_s.tx_os = OS_LAST;
          end
        end
      end
      ASP_TX_BUSY:
      begin
        if (mode == MODE_SHIFT)
        begin
          // two clocks per bit: low phase, then rising edge samples input
          if (s.tx_os == '0)
          begin
            next_s.sclk = 1'b0;
            next_s.tx_os = 4'h1;
          end
          else
          begin
            next_s.sclk = 1'b1;
            next_s.tx_os = '0;
            next_s.rx_shift = {s.sync2, s.rx_shift[9:1]};
            next_s.tx_cnt = s.tx_cnt - 4'h1;
            if (s.tx_cnt == 4'h1)
            begin
              next_s.tx_state = ASP_TX_IDLE;
              next_s.txf = 1'b1;
              load_rx = 1'b1;
              ld_data = f[9:2];
              // park the line high, or a later frame mode would start in a break
              next_s.txd = RST_LINE;
            end
            else
            begin
              next_s.txd = s.tx_shift[0];
              next_s.tx_shift = {1'b1, s.tx_shift[10:1]};
            end
          end
        end
        else if (os_tick)
        begin
          next_s.tx_os = s.tx_os + 4'h1;
          if (s.tx_os == OS_LAST)
          begin
            if (s.tx_cnt == '0)
            begin
              next_s.tx_state = ASP_TX_IDLE;
              next_s.txf = 1'b1;
            end
            else
            begin
              next_s.txd = s.tx_shift[0];
              next_s.tx_shift = {1'b1, s.tx_shift[10:1]};
              next_s.tx_cnt = s.tx_cnt - 4'h1;
            end
          end
        end
      end
    endcase

    // asynchronous receiver; idle in mode 0
    unique case (s.rx_state)
      ASP_RX_IDLE:
      begin
        next_s.rx_os = '0;
        if ((mode != MODE_SHIFT) && s.prev && !s.sync2)
          next_s.rx_state = ASP_RX_START;
      end
      ASP_RX_START:
      begin
        if (os_tick)
        begin
          next_s.rx_os = s.rx_os + 4'h1;
          if (s.rx_os == OS_MID)
          begin
            // a start bit gone high at mid-bit was a glitch
            next_s.rx_state = s.sync2 ? ASP_RX_IDLE : ASP_RX_DATA;
            next_s.rx_os = '0;
            next_s.rx_cnt = nine ? RX9_BITS : RX8_BITS;
          end
        end
      end
      ASP_RX_DATA:
      begin
        if (os_tick)
        begin
          next_s.rx_os = s.rx_os + 4'h1;
          if (s.rx_os == OS_LAST)
          begin
            next_s.rx_shift = f;
            next_s.rx_cnt = s.rx_cnt - 4'h1;
            if (s.rx_cnt == 4'h1)
            begin
              next_s.rx_state = ASP_RX_IDLE;
              load_rx = 1'b1;
              check_lin = 1'b1;
              ld_data = nine ? f[7:0] : f[8:1];
              ld_b9 = nine ? f[8] : f[9];
            end
          end
        end
      end
      default:
        next_s.rx_state = ASP_RX_IDLE;
    endcase
    if (mode == MODE_SHIFT)
      next_s.rx_state = ASP_RX_IDLE;

    // break: all-zero data plus a low stop bit (mode 1) or low ninth bit (modes 2/3); sync follows a break
    if (check_lin)
    begin
      if ((ld_data == '0) && !ld_b9)
      begin
        next_s.brk = 1'b1;
        next_s.brk_seen = 1'b1;
      end
      else
      begin
        if (s.brk_seen && (ld_data == SYNC_BYTE))
          next_s.syn = 1'b1;
        next_s.brk_seen = 1'b0;
      end
    end

    // holding register: a full, unread buffer keeps the older byte
    if (load_rx && rx_enable)
    begin
      if (s.full && !rd_strobe)
        next_s.ovr = 1'b1;
      else
      begin
        next_s.rx_data = ld_data;
        next_s.rx_b9 = ld_b9;
        next_s.full = 1'b1;
        next_s.rxf = 1'b1;
      end
    end

    next_s.busy = (next_s.tx_state == ASP_TX_BUSY);
    next_s.irq = next_s.txf || next_s.rxf;
    next_s.lin_txd = (IS_FIRST && !test_sel) ? next_s.txd : RST_LINE;
    next_s.gpio_txd = (IS_FIRST && !test_sel) ? RST_LINE : next_s.txd;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.sync1 <= RST_LINE;
      s.sync2 <= RST_LINE;
      s.prev <= RST_LINE;
      s.tx_state <= ASP_TX_IDLE;
      s.rx_state <= ASP_RX_IDLE;
      s.txd <= RST_LINE;
      s.sclk <= 1'b1;
      s.lin_txd <= RST_LINE;
      s.gpio_txd <= RST_LINE;
    end
    else
      s <= next_s;
  end

  assign serial_data_buffer = s.rx_data;
  assign rx_bit9   = s.rx_b9;
  assign tx_busy   = s.busy;
  assign rx_full   = s.full;
  assign tx_flag   = s.txf;
  assign rx_flag   = s.rxf;
  assign overrun   = s.ovr;
  assign brk_flag  = s.brk;
  assign sync_flag = s.syn;
  assign irq       = s.irq;
  assign lin_txd   = s.lin_txd;
  assign gpio_txd  = s.gpio_txd;
  assign shift_clk = s.sclk;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence shift_low_high;
    !shift_clk ##1 shift_clk;
  endsequence

  mode0_clock_a: assert property (
    (s.busy && mode == MODE_SHIFT && s.tx_os == '0 && s.tx_cnt != '0)
      |=> shift_low_high)
    else $error("mode 0 shift clock not at half rate");

  write_start_a: assert property (
    (tx_write && !s.busy && mode == MODE_SHIFT)
      |=> (tx_busy && s.txd == $past(tx_data[0])))
    else $error("write did not start transmission");

  mode2_tick_a: assert property (
    (os_tick && mode == MODE_9FIX) |=> (!os_tick || mode != MODE_9FIX) [*3])
    else $error("mode 2 tick spacing wrong");

  read_clear_a: assert property (
    (rd_strobe && s.rx_state == ASP_RX_IDLE && !s.busy) |=> !rx_full)
    else $error("read did not free receive buffer");

  set_wins_a: assert property (
    (load_rx && rx_enable && !(s.full && !rd_strobe) && clr_rx_flag)
      |=> rx_flag)
    else $error("receive flag lost against clear");

  overrun_keep_a: assert property (
    (load_rx && rx_enable && s.full && !rd_strobe)
      |=> (overrun && $stable(serial_data_buffer)))
    else $error("full buffer was overwritten");

  irq_rise_a: assert property (
    $rose(tx_flag) || $rose(rx_flag) |-> irq)
    else $error("completion without interrupt");

  break_det_a: assert property (
    (check_lin && ld_data == '0 && !ld_b9) |=> brk_flag)
    else $error("break not detected");

  tx_idle_a: assert property (
    (!s.busy && mode != MODE_SHIFT && !tx_write) |=> s.txd)
    else $error("line not idle high after frame");

endmodule

// *** asp_node.sv ***
/*
  Remote serial node facing the port: sends frames onto the port's receive
  pin and decodes frames from its transmit pin; also a mode 0 shift partner.
  Assumes the bench sets bit_clks, nbits and shift_mode before each use.
*/
`timescale 1ns/1ps
module asp_node
(
  // clock
  input  wire logic core_clk,
  // port side pins
  input  wire logic txd,
  input  wire logic shift_clk,
  output logic      rxd
);
  int         bit_clks   = 64;
  int         nbits      = 9;
  logic       shift_mode = 1'b0;
  logic [8:0] got        = 9'h000;
  logic [7:0] sh_out     = 8'h00;
  logic [7:0] sh_in      = 8'h00;

  // ------------------------------------------------------------------
  // frames towards the port
  // ------------------------------------------------------------------
  initial rxd = 1'b1;

  // a low stop bit lets the bench make a break; one idle bit follows
  task automatic send(input logic [8:0] d, input logic stop);
    for (int i = 0; i < nbits + 2; i++)
    begin
      @(posedge core_clk);
      rxd <= (i == 0) ? 1'b0 : (i > nbits) ? stop : d[i-1];
      repeat (bit_clks - 1) @(posedge core_clk);
    end
    @(posedge core_clk);
    rxd <= 1'b1;
    repeat (bit_clks) @(posedge core_clk);
  endtask

  // ------------------------------------------------------------------
  // frames from the port, sampled at bit centres
  // ------------------------------------------------------------------
  initial forever
  begin
    @(negedge txd);
    if (!shift_mode)
    begin
      got = 9'h000;
      repeat (bit_clks / 2) @(posedge core_clk);
      for (int i = 0; i < nbits; i++)
      begin
        repeat (bit_clks) @(posedge core_clk);
        got[i] = txd;
      end
    end
  end

  // mode 0: capture just before each clock rise, and move to the next
  // bit on each fall so the port's synchroniser has it in time
  always @(posedge core_clk)
    if (shift_mode && !shift_clk)
      sh_in <= {txd, sh_in[7:1]};

  always @(negedge shift_clk)
    if (shift_mode)
    begin
      rxd    <= sh_out[1];
      sh_out <= sh_out >> 1;
    end
endmodule

// *** asp_core_bench.sv ***
/*
  Bench for asp_core: random full-duplex frames in every mode plus corner
  cases, checked against asp_node.
  Assumes a 10 MHz core_clk and the node on the pin pair test_sel picks.
*/
`timescale 1ns/1ps
module asp_core_bench;
  import asp_pkg::*;

  // --------------------------------------------------------------
  // stimulus and observed signals
  // --------------------------------------------------------------
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        mode_select_high, mode_select_low, rx_enable, test_sel;
  logic [10:0] baud_reload;
  logic [7:0]  frac_step, tx_data, serial_data_buffer;
  logic        tx_write, tx_bit9, rd_strobe, clr_tx_flag, clr_rx_flag;
  logic        clr_err_flags, rx_bit9, tx_busy, rx_full, tx_flag, rx_flag;
  logic        overrun, brk_flag, sync_flag, irq, lin_txd, gpio_txd;
  logic        shift_clk, lin_rxd, gpio_rxd, node_txd, node_rxd;
  logic [8:0]  a, b;
  int          seed = 18;
  int          miscompares = 0;
  int          compares = 0;
  int          cycles = 0;
  int          dur, div, m, slack, den;

  // the node sits on the pin pair test_sel picks; the other rests high
  assign node_txd = test_sel ? gpio_txd : lin_txd;
  assign lin_rxd  = test_sel ? 1'b1 : node_rxd;
  assign gpio_rxd = test_sel ? node_rxd : 1'b1;

  asp_core #(.IS_FIRST(1'b1)) DUT
  (
    .core_clk, .sys_rst, .mode_select_high, .mode_select_low, .rx_enable,
    .test_sel, .baud_reload, .frac_step, .tx_write, .tx_data, .tx_bit9,
    .rd_strobe, .serial_data_buffer, .rx_bit9, .clr_tx_flag, .clr_rx_flag,
    .clr_err_flags, .tx_busy, .rx_full, .tx_flag, .rx_flag, .overrun,
    .brk_flag, .sync_flag, .irq, .lin_rxd, .gpio_rxd, .lin_txd, .gpio_txd,
    .shift_clk
  );

  asp_node node
  (
    .core_clk,
    .txd       (node_txd),
    .shift_clk,
    .rxd       (node_rxd)
  );

  always #50 core_clk = ~core_clk;

  // hang guard, well above the longest run of frames
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic check(input logic [9:0] seen, input logic [9:0] want);
    compares++;
    if (seen !== want)
    begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  // one-cycle strobe: 0 write, 1 read, 2/3/4 clear tx, rx, error flags
  task automatic strobe(input int k);
    @(posedge core_clk);
    {clr_err_flags, clr_rx_flag, clr_tx_flag, rd_strobe, tx_write} <= 5'(1 << k);
    @(posedge core_clk);
    {clr_err_flags, clr_rx_flag, clr_tx_flag, rd_strobe, tx_write} <= 5'h00;
  endtask

  // write and count the cycles the transmitter stays busy
  task automatic send_tx(input logic [8:0] d);
    @(posedge core_clk);
    {tx_bit9, tx_data} <= d;
    strobe(0);
    #1;
    dur = 0;
    for (int i = 0; i < 3 && tx_busy !== 1'b1; i++)
      tick();
    while (tx_busy === 1'b1 && dur < 20000)
    begin
      tick();
      dur++;
    end
  endtask

  task automatic setup(input int md, input int r, input logic [7:0] f);
    @(posedge core_clk);
    {mode_select_high, mode_select_low} <= 2'(md);
    baud_reload <= 11'(r);
    frac_step   <= f;
    test_sel    <= 1'($random(seed));
    div = (md == 2) ? 4 : r + 1;
    // each fractional carry stalls the generator a clock: bits stretch by 256/(256-f)
    den = 256 - int'(f);
    node.bit_clks   = (16 * div * 256 + den / 2) / den;
    node.nbits      = (md == 1) ? 8 : 9;
    node.shift_mode = (md == 0);
    repeat (8) @(posedge core_clk);
  endtask

  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial
  begin
    {mode_select_high, mode_select_low, test_sel, rx_enable} = 4'h1;
    {baud_reload, frac_step, tx_data, tx_bit9} = 28'h0000000;
    {tx_write, rd_strobe, clr_tx_flag, clr_rx_flag, clr_err_flags} = 5'h00;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    check({lin_txd, gpio_txd, shift_clk, tx_busy, rx_full, tx_flag, rx_flag, irq},
          10'h0E0);
    // full duplex in each asynchronous mode, last mode 3 round with a fraction
    for (int k = 0; k < 9; k++)
    begin
      m = 1 + k % 3;
      setup(m, 1 + ($random(seed) & 3), (m == 3 && k > 5) ? 8'h10 : 8'h00);
      a = 9'($random(seed));
      b = 9'($random(seed));
      fork
        send_tx(a);
        node.send(b, 1'b1);
      join
      repeat (4) @(posedge core_clk);
      slack = dur - 16 * div * ((m == 1) ? 10 : 11) * 256 / den;
      check(slack >= -2 && slack <= div + 13, 10'h001);
      check(node.got, a & {m != 1, 8'hFF});
      check({rx_bit9, serial_data_buffer}, {m == 1 | b[8], b[7:0]});
      check({tx_flag, rx_flag, irq, rx_full, overrun, brk_flag, sync_flag}, 10'h078);
      strobe(1);
      strobe(2);
      strobe(3);
      #1;
      check({tx_flag, rx_flag, irq, rx_full}, 10'h000);
      $display("frame test %0d in mode %0d done", k, m);
    end
    // second byte lands on an unread buffer: the new one is dropped
    setup(2, 0, 8'h00);
    node.send(9'h0A5, 1'b1);
    node.send(9'h15A, 1'b1);
    #1;
    check({overrun, rx_full, serial_data_buffer}, 10'h3A5);
    strobe(4);
    strobe(1);
    strobe(3);
    rx_enable <= 1'b0;
    node.send(9'h133, 1'b1);
    #1;
    check({overrun, rx_full, rx_flag}, 10'h000);
    @(posedge core_clk);
    rx_enable <= 1'b1;
    node.send(9'h000, 1'b0);
    node.send(9'h055, 1'b1);
    #1;
    check({brk_flag, sync_flag}, 10'h003);
    strobe(4);
    strobe(1);
    strobe(3);
    $display("overrun, disable and break tests done");
    // mode 0 exchange: eight bits each way at half the clock
    for (int k = 0; k < 2; k++)
    begin
      setup(0, 0, 8'h00);
      a = 9'($random(seed));
      b = 9'($random(seed));
      node.sh_out <= b[7:0];
      node.rxd    <= b[0];
      // a clear lands on the completing edge: the set must win
      fork
        send_tx(a);
        begin
          repeat (18) @(posedge core_clk);
          clr_rx_flag <= 1'b1;
          @(posedge core_clk);
          clr_rx_flag <= 1'b0;
        end
      join
      repeat (4) @(posedge core_clk);
      check(10'(dur), 10'h010);
      check({2'b00, node.sh_in}, {2'b00, a[7:0]});
      check({rx_bit9, serial_data_buffer}, {2'b00, b[7:0]});
      check({tx_flag, rx_flag, rx_full}, 10'h007);
      strobe(1);
      strobe(2);
      strobe(3);
      $display("shift test %0d done", k);
    end
    tally_and_finish();
  end
endmodule
